// [uart_holding_and_baud_regs.v]
// serial port with holding registers, baud divisor and status flags
// assumes one clock, a single-cycle register port, and a line partner
// that sends 8 data bits, no parity, one stop bit
//
// Design decision made here: the plain strobed port.
`include "uart_defines.vh"

module uart_holding_and_baud_regs #(
  parameter DATA_BITS = 8
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        arst_n_in,
  // register port
  input  wire [31:0] addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  // interrupt
  output wire        irq_out,
  // dma channel levels
  input  wire        tx_dma_buffer_empty_in,
  input  wire        rx_dma_buffer_full_in,
  // serial line
  input  wire        rxd_in,
  output reg         txd_out
);

  // receiver states
  localparam [1:0] RX_IDLE  = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_DATA  = 2'h2;
  localparam [1:0] RX_STOP  = 2'h3;
  // last data bit index, and last bit index of a frame, cut to counter width
  localparam integer RX_LAST_I = DATA_BITS - 1, TX_END_I = DATA_BITS + 1;
  localparam [3:0]   RX_LAST   = RX_LAST_I[3:0], TX_END = TX_END_I[3:0];

  reg  [1:0]             ctrl_r;
  reg  [15:0]            baud_divisor_value_r;
  reg  [15:0]            tick_cnt_r;
  reg                    tick_r;
  reg  [`EV_WIDTH-1:0]   ev_stat_r;
  reg  [`EV_WIDTH-1:0]   ev_en_r;
  reg  [DATA_BITS-1:0]   tx_holding_reg_r;
  reg                    tx_hold_full_r;
  reg  [DATA_BITS:0]     tx_shift_r;
  reg                    tx_busy_r;
  reg  [3:0]             tx_tick_r;
  reg  [3:0]             tx_bits_r;
  reg                    tx_idle_d_r;
  reg                    rxd_meta_r;
  reg                    rxd_sync_r;
  reg  [1:0]             rx_state_r;
  reg  [3:0]             rx_tick_r;
  reg  [3:0]             rx_bits_r;
  reg  [DATA_BITS-1:0]   rx_shift_r;
  reg  [DATA_BITS-1:0]   rx_holding_reg_r;
  reg                    rx_char_ready_r;
  wire                   rx_done;
  wire                   frame_err;
  wire                   rx_stop_end;
  reg  [`EV_WIDTH-1:0]   ev_set;
  reg  [31:0]            rdata_nxt;
  wire                   rx_en;
  wire                   tx_en;
  wire                   tx_holding_free;
  wire                   tx_idle_flag;
  wire                   tx_load;
  wire                   rd_rx_hold;

  // address match used by both read and write decode
  function hit;
    input [31:0] a;
    input [31:0] ref_addr;
    begin
      hit = (a == ref_addr);
    end
  endfunction

  assign rx_en      = ctrl_r[`CTRL_RX_EN];
  assign tx_en      = ctrl_r[`CTRL_TX_EN];
  assign rd_rx_hold = rd_in & hit(addr_in, `ADDR_RX_HOLD);

  // transmit flags from holding and shifter state
  assign tx_holding_free = tx_en & ~tx_hold_full_r;
  assign tx_idle_flag    = tx_en & ~tx_hold_full_r & ~tx_busy_r;
  assign tx_load         = tx_en & tx_hold_full_r & ~tx_busy_r;

  // control, divisor and interrupt enable registers
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl_r               <= `RST_CTRL;
      baud_divisor_value_r <= `RST_BAUD_DIV;
      ev_en_r              <= `RST_EV;
    end
    else if (wr_in)
    begin
      if (hit(addr_in, `ADDR_CTRL))
        ctrl_r <= wdata_in[1:0];
      if (hit(addr_in, `ADDR_BAUD_DIV))
        baud_divisor_value_r <= wdata_in[15:0];
      if (hit(addr_in, `ADDR_IRQ_EN))
        ev_en_r <= wdata_in[`EV_WIDTH-1:0];
    end
  end

  // sampling tick every divisor cycles; sixteen ticks make one bit
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tick_cnt_r <= 16'h0000;
      tick_r     <= 1'b0;
    end
    else if (baud_divisor_value_r == 16'h0000 || tick_cnt_r >= baud_divisor_value_r - 16'h0001)
    begin
      tick_cnt_r <= 16'h0000; // one tick per divisor clocks
      tick_r     <= (baud_divisor_value_r != 16'h0000); // zero stops the baud clock
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r     <= 1'b0;
    end
  end

  // transmit holding register and shifter
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tx_holding_reg_r <= {DATA_BITS{1'b0}};
      tx_hold_full_r   <= 1'b0;
      tx_shift_r       <= {(DATA_BITS+1){1'b1}};
      tx_busy_r        <= 1'b0;
      tx_tick_r        <= 4'h0;
      tx_bits_r        <= 4'h0;
      txd_out          <= 1'b1;
    end
    else
    begin
      if (wr_in && hit(addr_in, `ADDR_TX_HOLD))
      begin
        tx_holding_reg_r <= wdata_in[DATA_BITS-1:0];
        tx_hold_full_r   <= 1'b1;
      end
      else if (tx_load)
        tx_hold_full_r <= 1'b0;
      if (tx_load)
      begin
        tx_shift_r <= {1'b1, tx_holding_reg_r};
        tx_busy_r  <= 1'b1;
        tx_tick_r  <= 4'h0;
        tx_bits_r  <= 4'h0;
        txd_out    <= 1'b0; // start bit
      end
      else if (tx_busy_r && tick_r)
      begin
        tx_tick_r <= tx_tick_r + 4'h1;
        if (tx_tick_r == `TICK_LAST)
        begin
          if (tx_bits_r == TX_END)
          begin
            tx_busy_r <= 1'b0; // stop bit finished
            txd_out   <= 1'b1;
          end
          else
          begin
            txd_out    <= tx_shift_r[0];
            tx_shift_r <= {1'b1, tx_shift_r[DATA_BITS:1]};
            tx_bits_r  <= tx_bits_r + 4'h1;
          end
        end
      end
    end
  end

  // two flip-flop synchroniser on the receive pin
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rxd_meta_r <= 1'b1;
      rxd_sync_r <= 1'b1;
    end
    else
    begin
      rxd_meta_r <= rxd_in;
      rxd_sync_r <= rxd_meta_r;
    end
  end

  // receive framer: start check at half bit, data and stop at full bits
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rx_state_r <= RX_IDLE;
      rx_tick_r  <= 4'h0;
      rx_bits_r  <= 4'h0;
      rx_shift_r <= {DATA_BITS{1'b0}};
    end
    else if (!rx_en)
      rx_state_r <= RX_IDLE;
    else if (rx_state_r == RX_IDLE)
    begin
      rx_tick_r <= 4'h0;
      rx_bits_r <= 4'h0;
      if (!rxd_sync_r)
        rx_state_r <= RX_START;
    end
    else if (tick_r)
    begin
      rx_tick_r <= rx_tick_r + 4'h1;
      case (rx_state_r)
        RX_START:
          if (rx_tick_r == `HALF_LAST)
          begin
            rx_tick_r  <= 4'h0;
            rx_state_r <= rxd_sync_r ? RX_IDLE : RX_DATA; // reject glitches
          end
        RX_DATA:
          if (rx_tick_r == `TICK_LAST)
          begin
            rx_shift_r <= {rxd_sync_r, rx_shift_r[DATA_BITS-1:1]};
            rx_bits_r  <= rx_bits_r + 4'h1;
            if (rx_bits_r == RX_LAST)
              rx_state_r <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick_r == `TICK_LAST)
            rx_state_r <= RX_IDLE;
        default:
          rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // end of character: good stop bit or framing error
  assign rx_stop_end = rx_en & tick_r & (rx_state_r == RX_STOP) & (rx_tick_r == `TICK_LAST);
  assign rx_done     = rx_stop_end & rxd_sync_r;
  assign frame_err   = rx_stop_end & ~rxd_sync_r;

  // receive holding register and ready flag; a new character beats the read
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rx_holding_reg_r <= {DATA_BITS{1'b0}};
      rx_char_ready_r  <= 1'b0;
    end
    else if (!rx_en)
      rx_char_ready_r <= 1'b0;
    else if (rx_done)
    begin
      rx_holding_reg_r <= rx_shift_r;
      rx_char_ready_r  <= 1'b1;
    end
    else if (rd_rx_hold)
      rx_char_ready_r <= 1'b0;
  end

  // event sources for the sticky status
  always @*
  begin
    ev_set                = {`EV_WIDTH{1'b0}};
    ev_set[`EV_RX_DONE]   = rx_done;
    ev_set[`EV_TX_FREE]   = tx_load;
    ev_set[`EV_TX_IDLE]   = tx_idle_flag & ~tx_idle_d_r;
    ev_set[`EV_FRAME_ERR] = frame_err;
    ev_set[`EV_OVERRUN]   = rx_done & rx_char_ready_r & ~rd_rx_hold;
  end

  // sticky events; a set in the clearing cycle wins
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ev_stat_r   <= `RST_EV;
      tx_idle_d_r <= 1'b0;
    end
    else
    begin
      tx_idle_d_r <= tx_idle_flag;
      if (wr_in && hit(addr_in, `ADDR_IRQ_CLR))
        ev_stat_r <= (ev_stat_r & ~wdata_in[`EV_WIDTH-1:0]) | ev_set;
      else
        ev_stat_r <= ev_stat_r | ev_set;
    end
  end

  assign irq_out = |(ev_stat_r & ev_en_r);

  // read mux; unmapped and write-only addresses read as zero
  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit(addr_in, `ADDR_CTRL))
      rdata_nxt[1:0] = ctrl_r;
    else if (hit(addr_in, `ADDR_IRQ_STAT))
      rdata_nxt[`EV_WIDTH-1:0] = ev_stat_r;
    else if (hit(addr_in, `ADDR_IRQ_EN))
      rdata_nxt[`EV_WIDTH-1:0] = ev_en_r;
    else if (hit(addr_in, `ADDR_STATUS))
    begin
      rdata_nxt[`ST_RX_READY]    = rx_char_ready_r;
      rdata_nxt[`ST_TX_FREE]     = tx_holding_free;
      rdata_nxt[`ST_TX_IDLE]     = tx_idle_flag;
      rdata_nxt[`ST_TX_DMA_EMP]  = tx_dma_buffer_empty_in;
      rdata_nxt[`ST_RX_DMA_FULL] = rx_dma_buffer_full_in;
    end
    else if (hit(addr_in, `ADDR_RX_HOLD))
      rdata_nxt[DATA_BITS-1:0] = rx_holding_reg_r;
    else if (hit(addr_in, `ADDR_BAUD_DIV))
      rdata_nxt[15:0] = baud_divisor_value_r;
  end

  // read data stands in the cycle after the strobe only
  always @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdata_out <= 32'h0000_0000;
    else
      rdata_out <= rd_in ? rdata_nxt : 32'h0000_0000;
  end

endmodule // uart_holding_and_baud_regs

// [uart_defines.vh]
// register map, field positions, reset values and counts of the serial port
// assumes a 32-bit register port addressed by byte address
`ifndef UART_DEFINES_VH
`define UART_DEFINES_VH

// register byte addresses
`define ADDR_CTRL      32'h400E_0600
`define ADDR_IRQ_STAT  32'h400E_0604
`define ADDR_IRQ_EN    32'h400E_0608
`define ADDR_IRQ_CLR   32'h400E_060C
`define ADDR_STATUS    32'h400E_0614
`define ADDR_RX_HOLD   32'h400E_0618
`define ADDR_TX_HOLD   32'h400E_061C
`define ADDR_BAUD_DIV  32'h400E_0620

// control fields
`define CTRL_RX_EN     0
`define CTRL_TX_EN     1

// status fields
`define ST_RX_READY    0
`define ST_TX_FREE     1
`define ST_TX_IDLE     9
`define ST_TX_DMA_EMP  11
`define ST_RX_DMA_FULL 12

// interrupt event fields
`define EV_RX_DONE     0
`define EV_TX_FREE     1
`define EV_TX_IDLE     2
`define EV_FRAME_ERR   3
`define EV_OVERRUN     4
`define EV_WIDTH       5

// reset values
`define RST_CTRL       2'h0
`define RST_BAUD_DIV   16'h0000
`define RST_EV         5'h00

// last tick index of a sixteen-tick bit, and of its first half
`define TICK_LAST      4'hF
`define HALF_LAST      4'h7

`endif

// [uart_regs_sva.sv]
// concurrent checks on the register port and the status flags
// assumes the register map header is on the include path
`include "uart_defines.vh"
module uart_regs_sva (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  // register port
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  // dma levels
  input wire logic        tx_dma_buffer_empty_in,
  input wire logic        rx_dma_buffer_full_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // read data only in the cycle after a read
  a_rd_data_zero: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
    else $error("read data outside read cycle");
  // status mirrors the dma levels of the read cycle
  a_dma_empty_bit: assert property (rd_in && addr_in == `ADDR_STATUS
    |=> rdata_out[`ST_TX_DMA_EMP] == $past(tx_dma_buffer_empty_in))
    else $error("tx dma empty level wrong");
  a_dma_full_bit: assert property (rd_in && addr_in == `ADDR_STATUS
    |=> rdata_out[`ST_RX_DMA_FULL] == $past(rx_dma_buffer_full_in))
    else $error("rx dma full level wrong");
  // a holding write drops both transmit flags at once
  a_thr_wr_clears: assert property ((wr_in && addr_in == `ADDR_TX_HOLD)
    ##1 (rd_in && addr_in == `ADDR_STATUS)
    |=> !rdata_out[`ST_TX_FREE] && !rdata_out[`ST_TX_IDLE])
    else $error("tx flags set after holding write");
  // idle is never shown while a character waits
  a_idle_needs_free: assert property (rd_in && addr_in == `ADDR_STATUS
    |=> !rdata_out[`ST_TX_IDLE] || rdata_out[`ST_TX_FREE])
    else $error("idle without free holding");
  a_rhr_low_byte: assert property (rd_in && addr_in == `ADDR_RX_HOLD
    |=> rdata_out[31:8] == 24'h00_0000)
    else $error("receive holding upper bits set");
  a_thr_reads_zero: assert property (rd_in && addr_in == `ADDR_TX_HOLD
    |=> rdata_out == 32'h0000_0000)
    else $error("transmit holding readable");
  a_baud_readback: assert property ((wr_in && addr_in == `ADDR_BAUD_DIV)
    ##1 (rd_in && addr_in == `ADDR_BAUD_DIV)
    |=> rdata_out == {16'h0000, $past(wdata_in[15:0], 2)})
    else $error("divisor readback wrong");
  a_rx_read_clears: assert property ((rd_in && addr_in == `ADDR_RX_HOLD)
    ##2 (rd_in && addr_in == `ADDR_STATUS) |=> !rdata_out[`ST_RX_READY])
    else $error("ready stays after holding read");
endmodule // uart_regs_sva

bind uart_holding_and_baud_regs uart_regs_sva chk_u (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .tx_dma_buffer_empty_in(tx_dma_buffer_empty_in),
  .rx_dma_buffer_full_in(rx_dma_buffer_full_in));

// [line_partner.sv]
// remote serial device: decodes frames from the port, sends frames to it
// assumes 8 data bits lsb first, one stop bit, bit time set by the bench
module line_partner (
  // clock
  input  wire logic clk_in,
  // serial line
  input  wire logic txd_in,
  output logic      rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_clks = 16;
  logic [7:0] got[$];
  logic [7:0] b;
  initial rxd_out = 1'b1;
  // sample each bit in its middle after the start edge
  always
  begin
    @(negedge txd_in);
    repeat (bit_clks / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_clks) @(posedge clk_in);
      b[i] = txd_in;
    end
    repeat (bit_clks) @(posedge clk_in);
    got.push_back(b);
  end
  // one frame: start low, data lsb first, stop high, idle stays high
  task send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_in);
      rxd_out <= f[i];
      repeat (bit_clks - 1) @(posedge clk_in);
    end
  endtask
endmodule // line_partner

// [uart_holding_and_baud_regs_tb_top.sv]
// self-checking bench for the serial port registers and flags
// assumes the line partner model and the register map header
`include "uart_defines.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module uart_holding_and_baud_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic        tx_dma_empty = 1'b0, rx_dma_full = 1'b0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d;
  wire         irq, txd, rxd;
  int          bad_count = 0, compares = 0, t0, dt;
  always #5 clk = ~clk;
  uart_holding_and_baud_regs dut_u (.clk_in(clk), .arst_n_in(arst_n), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
    .tx_dma_buffer_empty_in(tx_dma_empty), .rx_dma_buffer_full_in(rx_dma_full),
    .rxd_in(rxd), .txd_out(txd));
  line_partner partner_u (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
  // counts, verdict and end of run
  task give_verdict();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bus cycles: one-cycle strobes, read data taken the cycle after
  task wr_c(input logic [31:0] a, v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task rd_c(input logic [31:0] a, output logic [31:0] q);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 q = rdata;
  endtask
  task wr_rd(input logic [31:0] wa, v, ra, output logic [31:0] q);
    @(posedge clk); addr <= wa; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0; rd <= 1'b1; addr <= ra;
    @(posedge clk); rd <= 1'b0;
    #1 q = rdata;
  endtask
  // bounded poll of one status bit
  task wait_st(input int n, input logic v);
    for (int i = 0; i < 3000; i++)
    begin
      rd_c(`ADDR_STATUS, d);
      if (d[n] === v) return;
    end
    bad_count++;
    give_verdict();
  endtask
  // reset values and an unmapped place
  task t_reset();
    rd_c(`ADDR_BAUD_DIV, d); `CHK("baud reset", 32'h0, d)
    rd_c(`ADDR_STATUS, d); `CHK("status reset", 32'h0, d)
    rd_c(32'h400E_0700, d); `CHK("unmapped", 32'h0, d)
  endtask
  // all four dma level pairs
  task t_dma();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk); tx_dma_empty <= i[0]; rx_dma_full <= i[1];
      rd_c(`ADDR_STATUS, d);
      `CHK("dma empty", i[0], d[11])
      `CHK("dma full", i[1], d[12])
    end
  endtask
  // divisor width, both ends of the range
  task t_baud();
    wr_rd(`ADDR_BAUD_DIV, 32'hFFFF_FFFF, `ADDR_BAUD_DIV, d);
    `CHK("baud max", 32'h0000_FFFF, d)
    wr_rd(`ADDR_BAUD_DIV, 32'h1, `ADDR_BAUD_DIV, d); `CHK("baud one", 32'h1, d)
  endtask
  // two characters back to back
  task t_tx();
    wr_c(`ADDR_CTRL, 32'h3); rd_c(`ADDR_STATUS, d);
    `CHK("free", 1'b1, d[1])
    `CHK("idle", 1'b1, d[9])
    wr_rd(`ADDR_TX_HOLD, 32'h0000_01A5, `ADDR_STATUS, d);
    `CHK("free after wr", 1'b0, d[1])
    `CHK("idle after wr", 1'b0, d[9])
    wait_st(1, 1'b1);
    wr_c(`ADDR_TX_HOLD, 32'h3C); rd_c(`ADDR_TX_HOLD, d);
    `CHK("thr unreadable", 32'h0, d)
    rd_c(`ADDR_STATUS, d);
    `CHK("idle busy", 1'b0, d[9])
    wait_st(9, 1'b1);
    `CHK("char one", 8'hA5, partner_u.got[0])
    `CHK("char two", 8'h3C, partner_u.got[1])
  endtask
  // frame length 10 bits of 16 times divisor, then a stopped divisor
  task t_rate();
    wr_c(`ADDR_BAUD_DIV, 32'h2); partner_u.bit_clks = 32; partner_u.got.delete();
    wr_c(`ADDR_TX_HOLD, 32'h5A); t0 = $time;
    wait_st(9, 1'b1); dt = ($time - t0) / 10;
    `CHK("frame length", 1'b1, (dt >= 310 && dt <= 340))
    `CHK("char slow", 8'h5A, partner_u.got[0])
    wr_c(`ADDR_BAUD_DIV, 32'h0); wr_c(`ADDR_TX_HOLD, 32'h11);
    repeat (400) @(posedge clk);
    rd_c(`ADDR_STATUS, d); `CHK("stalled", 1'b0, d[9])
    wr_c(`ADDR_BAUD_DIV, 32'h1); partner_u.bit_clks = 16; wait_st(9, 1'b1);
  endtask
  // receive with interrupt raised, masked, cleared
  task t_rx();
    wr_c(`ADDR_IRQ_EN, 32'h1); partner_u.send(8'hC3); wait_st(0, 1'b1);
    `CHK("irq on", 1'b1, irq)
    wr_c(`ADDR_IRQ_EN, 32'h0); #1 `CHK("irq masked", 1'b0, irq)
    wr_c(`ADDR_IRQ_CLR, 32'h1); wr_c(`ADDR_IRQ_EN, 32'h1); #1 `CHK("irq cleared", 1'b0, irq)
    rd_c(`ADDR_RX_HOLD, d); `CHK("rx char", 32'h0000_00C3, d)
    rd_c(`ADDR_STATUS, d); `CHK("ready cleared", 1'b0, d[0])
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset(); t_dma(); t_baud(); t_tx(); t_rate(); t_rx();
    give_verdict();
  end
endmodule // uart_holding_and_baud_regs_tb_top
